/* File: verilog/nand_host.v */
`timescale 1ns/1ns
`include "nand_host_defs.vh"
// Overview of operation
// - send five address bytes for two-plane part, four for one-plane part
// - byte 1 column 7:0; byte 2 column 11:8, upper lines low
// - byte 3 block 1:0 and page; byte 4 block 9:2; byte 5 block 10
// - column bit 12 low; with column bit 11 set bits 10:7 low
// - command cycle: select low, cle high, ale low, read strobe high
// - address cycle: select low, ale high, cle low, read strobe high
// - data-in cycle: select low, both latches low, write protect high (here write protect just follows wp_allow_in)
// - data bytes go out one per write strobe, in order
// - read one byte per read strobe, write strobe high, latches low
// - hold write protect high through program or erase setup (here it follows wp_allow_in one cycle late outside reset; reset drives it low)
// - keep read strobe high while device is busy reading
module nand_host
(
  input wire clock_in,
  input wire nrst_in,
  // user request
  input wire [1:0] op_in,
  input wire [7:0] op_data_in,
  input wire [`COL_W-1:0] column_addr_in,
  input wire [`PAGE_W-1:0] page_addr_in,
  input wire [`BLOCK_W-1:0] block_in,
  input wire two_plane_in,
  input wire wp_allow_in,
  input wire op_valid_in,
  output reg op_ready_out,
  // read data stream
  output wire [7:0] rd_data_out,
  output wire rd_valid_out,
  input wire rd_ready_in,
  output reg busy_out,
  // flash pins
  output reg chip_sel_n_out,
  output reg cmd_latch_out,
  output reg addr_latch_out,
  output reg write_strobe_n_out,
  output reg read_strobe_n_out,
  output reg write_prot_n_out,
  input wire [7:0] io_in,
  output reg [7:0] io_out,
  output reg io_oe_n_out,
  input wire ready_busy_n_in
);
  localparam ST_IDLE = 3'h0;
  localparam ST_WLOW = 3'h1;
  localparam ST_WHIGH = 3'h2;
  localparam ST_RLOW = 3'h3;
  localparam ST_RHIGH = 3'h4;
  localparam ST_PUSH = 3'h5;
  reg [2:0] state_r;
  reg [`CNT_W-1:0] cnt_r;
  reg [2:0] byte_idx_r;
  reg [2:0] byte_cnt_r;
  reg [1:0] op_r;
  reg [`ROW_W-1:0] row_r;
  reg [`COL_W-1:0] col_r;
  reg [7:0] rd_byte_r;
  reg push_r;
  reg [7:0] addr_byte;
  wire fifo_ready;
  wire timer_done;
  ////////////////////////////////////////////////////////////////////////
  // read bytes pass through the fifo; a full fifo stalls the next read
  byte_fifo #(
    .WIDTH(8),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .wr_data_in(rd_byte_r),
    .wr_valid_in(push_r),
    .wr_ready_out(fifo_ready),
    .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out),
    .rd_ready_in(rd_ready_in)
  );
  assign timer_done = (cnt_r == `STROBE_CYC - 1);
  ////////////////////////////////////////////////////////////////////////
  // address byte formatter, row is block above page
  always @*
  begin
    case (byte_idx_r)
      3'h0: addr_byte = col_r[7:0];
      3'h1: addr_byte = {4'h0, col_r[11:8]};
      3'h2: addr_byte = row_r[7:0];
      3'h3: addr_byte = row_r[15:8];
      3'h4: addr_byte = {7'h00, row_r[16]};
      default: addr_byte = 8'h00;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////
  // strobe sequencer
  always @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      state_r <= ST_IDLE;
      cnt_r <= {`CNT_W{1'b0}};
      byte_idx_r <= 3'h0;
      byte_cnt_r <= 3'h0;
      op_r <= `OP_CMD;
      row_r <= {`ROW_W{1'b0}};
      col_r <= {`COL_W{1'b0}};
      rd_byte_r <= 8'h00;
      push_r <= 1'b0;
      busy_out <= 1'b0;
      op_ready_out <= 1'b0;
      chip_sel_n_out <= 1'b1;
      cmd_latch_out <= 1'b0;
      addr_latch_out <= 1'b0;
      write_strobe_n_out <= 1'b1;
      read_strobe_n_out <= 1'b1;
      write_prot_n_out <= 1'b0;
      io_out <= 8'h00;
      io_oe_n_out <= 1'b1;
    end
    else
    begin
      push_r <= 1'b0;
      write_prot_n_out <= wp_allow_in;
      // ready when idle, device ready and room for a read byte;
      // a push still in flight holds it low one more cycle
      op_ready_out <= (state_r == ST_IDLE) && ready_busy_n_in &&
        !(op_valid_in && op_ready_out) && fifo_ready && !push_r;
      case (state_r)
        ST_IDLE:
        begin
          cnt_r <= {`CNT_W{1'b0}};
          write_strobe_n_out <= 1'b1;
          read_strobe_n_out <= 1'b1;
          if (op_valid_in && op_ready_out)
          begin
            op_r <= op_in;
            busy_out <= 1'b1;
            chip_sel_n_out <= 1'b0;
            byte_idx_r <= 3'h0;
            col_r <= column_addr_in[11] ?
              (column_addr_in & `COL_SPARE_MASK) : column_addr_in;
            // block 10 exists only on the two-plane part
            row_r <= {two_plane_in & block_in[10], block_in[9:0],
              page_addr_in};
            byte_cnt_r <= two_plane_in ? `ADDR_BYTES_LARGE :
              `ADDR_BYTES_SMALL;
            cmd_latch_out <= (op_in == `OP_CMD);
            addr_latch_out <= (op_in == `OP_ADDR);
            io_out <= op_data_in;
            if (op_in == `OP_READ)
            begin
              // latches low, write strobe high, read strobe toggles
              io_oe_n_out <= 1'b1;
              state_r <= ST_RLOW;
            end
            else
            begin
              io_oe_n_out <= 1'b0;
              state_r <= ST_WLOW;
            end
          end
          else
          begin
            busy_out <= 1'b0;
            chip_sel_n_out <= 1'b1;
            cmd_latch_out <= 1'b0;
            addr_latch_out <= 1'b0;
            io_oe_n_out <= 1'b1;
          end
        end
        ST_WLOW:
        begin
          write_strobe_n_out <= 1'b0;
          if (op_r == `OP_ADDR)
            io_out <= addr_byte;
          cnt_r <= timer_done ? {`CNT_W{1'b0}} : cnt_r + 1'b1;
          if (timer_done)
            state_r <= ST_WHIGH;
        end
        ST_WHIGH:
        begin
          // rising strobe latches cmd, address or data byte
          write_strobe_n_out <= 1'b1;
          cnt_r <= timer_done ? {`CNT_W{1'b0}} : cnt_r + 1'b1;
          if (timer_done)
          begin
            if (op_r == `OP_ADDR &&
              byte_idx_r + 3'h1 != byte_cnt_r)
            begin
              byte_idx_r <= byte_idx_r + 3'h1;
              state_r <= ST_WLOW;
            end
            else
              state_r <= ST_IDLE;
          end
        end
        ST_RLOW:
        begin
          read_strobe_n_out <= 1'b0;
          cnt_r <= timer_done ? {`CNT_W{1'b0}} : cnt_r + 1'b1;
          if (timer_done)
          begin
            rd_byte_r <= io_in;
            state_r <= ST_RHIGH;
          end
        end
        ST_RHIGH:
        begin
          read_strobe_n_out <= 1'b1;
          cnt_r <= timer_done ? {`CNT_W{1'b0}} : cnt_r + 1'b1;
          if (timer_done)
            state_r <= ST_PUSH;
        end
        ST_PUSH:
        begin
          push_r <= 1'b1;
          state_r <= ST_IDLE;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end
endmodule // nand_host

/* File: verilog/nand_host_defs.vh */
`ifndef NAND_HOST_DEFS_VH
`define NAND_HOST_DEFS_VH
// user-side operation codes
`define OP_CMD 2'h0
`define OP_ADDR 2'h1
`define OP_WRITE 2'h2
`define OP_READ 2'h3
// address field layout
`define COL_W 12
`define PAGE_W 6
`define BLOCK_W 11
`define ROW_W 17
// column bit 11 set forces bits 10:7 low
`define COL_SPARE_MASK 12'h87f
`define ADDR_BYTES_LARGE 3'h5
`define ADDR_BYTES_SMALL 3'h4
// strobe timing: low and high phase of each strobe in ns, 10 MHz clock
`define STROBE_NS 200
`define CLK_NS 100
`define STROBE_CYC ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define CNT_W 4
// fifo geometry
`define FIFO_DEPTH 4
`define FIFO_AW 2
`endif

/* File: verilog/byte_fifo.v */
`timescale 1ns/1ns
// small synchronous fifo with valid/ready on both sides
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
)
(
  input wire clock_in,
  input wire nrst_in,
  input wire [WIDTH-1:0] wr_data_in,
  input wire wr_valid_in,
  output wire wr_ready_out,
  output wire [WIDTH-1:0] rd_data_out,
  output wire rd_valid_out,
  input wire rd_ready_in
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;
  ////////////////////////////////////////////////////////////////////////
  // honest full and empty from the fill count
  assign wr_ready_out = (count_r != DEPTH[AW:0]);
  assign rd_valid_out = (count_r != {(AW+1){1'b0}});
  assign rd_data_out = mem_r[rd_ptr_r];
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_valid_out && rd_ready_in;
  // storage write
  always @(posedge clock_in)
  begin
    if (push)
      mem_r[wr_ptr_r] <= wr_data_in;
  end
  // pointers and count
  always @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      if (push && !pop)
        count_r <= count_r + {{AW{1'b0}}, 1'b1};
      else if (pop && !push)
        count_r <= count_r - {{AW{1'b0}}, 1'b1};
    end
  end
endmodule // byte_fifo

/* File: verif/nand_host_chk.sv */
`timescale 1ns/1ns
// pin sequencing checks for the host controller
module nand_host_chk
(
  input wire clock_in,
  input wire nrst_in,
  input wire wp_allow_in,
  input wire op_ready_out,
  input wire rd_valid_out,
  input wire busy_out,
  input wire chip_sel_n_out,
  input wire cmd_latch_out,
  input wire addr_latch_out,
  input wire write_strobe_n_out,
  input wire read_strobe_n_out,
  input wire write_prot_n_out,
  input wire [7:0] io_out,
  input wire io_oe_n_out,
  input wire ready_busy_n_in
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  ////////////////////////////////////////////////////////////////
  // one write strobe: low phase then high
  sequence we_pulse;
    !write_strobe_n_out ##1 write_strobe_n_out;
  endsequence
  a_select_idle: assert property (!chip_sel_n_out |-> busy_out)
    else $error("select low while idle");
  a_cmd_levels: assert property (cmd_latch_out |-> !chip_sel_n_out
    && !addr_latch_out && read_strobe_n_out) else $error("bad command");
  a_addr_levels: assert property (addr_latch_out |-> !chip_sel_n_out
    && !cmd_latch_out && read_strobe_n_out) else $error("bad address");
  a_write_drive: assert property (!write_strobe_n_out |-> !io_oe_n_out
    && !chip_sel_n_out && read_strobe_n_out) else $error("bad write");
  a_strobe_shape: assert property ($fell(write_strobe_n_out) |->
    ##1 we_pulse) else $error("write strobe shape");
  a_data_hold: assert property ($rose(write_strobe_n_out) |->
    $stable(io_out) && !io_oe_n_out) else $error("data moved at edge");
  a_read_levels: assert property (!read_strobe_n_out |->
    write_strobe_n_out && !cmd_latch_out && !addr_latch_out
    && !chip_sel_n_out && io_oe_n_out) else $error("bad read");
  a_read_lands: assert property ($rose(read_strobe_n_out) |->
    ##[1:4] rd_valid_out) else $error("read byte lost");
  a_wp_level: assert property ($past(nrst_in) |->
    write_prot_n_out == $past(wp_allow_in)) else $error("wp level");
  a_busy_hold: assert property (!ready_busy_n_in |=>
    !op_ready_out) else $error("request while busy");
endmodule // nand_host_chk

/* File: verif/nand_dev.sv */
`timescale 1ns/1ns
// behavioural flash device on the pins
module nand_dev #(
  parameter ID = 8'h5c, // id value is arbitrary
  parameter GLITCH_NS = 5,
  parameter BUSY_NS = 3020 // ends off the host clock edge
)
(
  input wire cs_n_in,
  input wire cle_in,
  input wire ale_in,
  input wire we_n_in,
  input wire re_n_in,
  input wire wp_n_in,
  input wire [7:0] io_in,
  output wire [7:0] io_out,
  output reg rb_n_out
);
  reg [7:0] ab [0:4];
  reg [7:0] buf_m [0:15];
  reg [2:0] acnt = 3'h0;
  reg [3:0] col = 4'h0;
  reg [3:0] pcnt = 4'h0;
  reg [7:0] cmd = 8'h00;
  reg [7:0] dq = 8'h00;
  time we_fall_t = 0;
  initial rb_n_out = 1'b1;
  // time of the last falling write strobe, for the glitch filter
  always @(negedge we_n_in)
    we_fall_t = $time;
  ////////////////////////////////////////////////////////////////
  // latch on rising write strobe; other combinations ignored
  always @(posedge we_n_in)
    if (!cs_n_in && re_n_in && ($time - we_fall_t >= GLITCH_NS))
    begin
      if (cle_in && !ale_in)
      begin
        cmd = io_in;
        acnt = 3'h0;
        if (io_in == 8'h10 && wp_n_in)
          pcnt = pcnt + 4'h1;
        if (io_in == 8'h30)
        begin
          rb_n_out = 1'b0;
          rb_n_out <= #BUSY_NS 1'b1;
        end
      end
      else if (ale_in && !cle_in)
      begin
        if (acnt == 3'h0)
          col = io_in[3:0];
        ab[acnt] = io_in;
        acnt = acnt + 3'h1;
      end
      else if (!cle_in && !ale_in && wp_n_in)
      begin
        buf_m[col] = io_in;
        col = col + 4'h1;
      end
    end
  // shift out on falling read strobe
  always @(negedge re_n_in)
    if (!cs_n_in && we_n_in && !cle_in && !ale_in)
    begin
      dq = (cmd == 8'h90) ? ID : buf_m[col];
      col = col + 4'h1;
    end
  // released bus shows a flipped value
  assign io_out = (!cs_n_in && !re_n_in) ? dq : ~dq;
endmodule // nand_dev

/* File: verif/tb_top.sv */
`timescale 1ns/1ns
`include "nand_host_defs.vh"
`define CHK(a, b) begin checks = checks + 1; if ((a) !== (b)) begin \
  err_count = err_count + 1; $display("MISMATCH %0t %h %h", $time, a, b); \
  end end
module tb_top;
  reg clock_in = 0;
  reg nrst_in = 0;
  reg [1:0] op_in = 0;
  reg [7:0] op_data_in = 0;
  reg [`COL_W-1:0] col = 0;
  reg [`PAGE_W-1:0] pg = 0;
  reg [`BLOCK_W-1:0] blk = 0;
  reg tp = 0;
  reg wp = 1;
  reg op_valid_in = 0;
  reg rd_ready_in = 0;
  integer err_count = 0;
  integer checks = 0;
  integer i;
  wire [7:0] rd_data_out, io_out, dev_io;
  wire op_ready_out, rd_valid_out, busy_out, cs_n, cle, ale, we_n, re_n;
  wire wp_n, io_oe_n_out, rb_n;
  wire [7:0] bus = io_oe_n_out ? dev_io : io_out;
  always #50 clock_in = ~clock_in;
  nand_host dut_u (.clock_in(clock_in), .nrst_in(nrst_in), .op_in(op_in),
    .op_data_in(op_data_in), .column_addr_in(col), .page_addr_in(pg),
    .block_in(blk), .two_plane_in(tp), .wp_allow_in(wp),
    .op_valid_in(op_valid_in), .op_ready_out(op_ready_out),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
    .rd_ready_in(rd_ready_in), .busy_out(busy_out), .chip_sel_n_out(cs_n),
    .cmd_latch_out(cle), .addr_latch_out(ale), .write_strobe_n_out(we_n),
    .read_strobe_n_out(re_n), .write_prot_n_out(wp_n), .io_in(bus),
    .io_out(io_out), .io_oe_n_out(io_oe_n_out), .ready_busy_n_in(rb_n));
  nand_dev dev_u (.cs_n_in(cs_n), .cle_in(cle), .ale_in(ale), .we_n_in(we_n),
    .re_n_in(re_n), .wp_n_in(wp_n), .io_in(bus), .io_out(dev_io),
    .rb_n_out(rb_n));
  ////////////////////////////////////////////////////////////////
  task summarize;
    begin
      if (err_count == 0 && checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // bounded wait on ready, take, then bounded wait on idle
  task go(input [1:0] o, input [7:0] d);
    begin
      @(posedge clock_in);
      op_in <= o;
      op_data_in <= d;
      op_valid_in <= 1'b1;
      @(negedge clock_in);
      for (i = 0; i < 300 && op_ready_out !== 1'b1; i = i + 1)
        @(negedge clock_in);
      @(posedge clock_in);
      op_valid_in <= 1'b0;
      @(negedge clock_in);
      for (i = i; i < 300 && busy_out !== 1'b0; i = i + 1)
        @(negedge clock_in);
      if (i >= 300)
      begin
        err_count = err_count + 1;
        summarize;
      end
    end
  endtask
  task t_addr(input t, input [11:0] c, input [5:0] p, input [10:0] b);
    reg [11:0] ce;
    begin
      // column bit 11 set sends bits 10:7 low
      ce = {c[11], c[11] ? 4'h0 : c[10:7], c[6:0]};
      @(posedge clock_in);
      tp <= t;
      col <= c;
      pg <= p;
      blk <= b;
      go(`OP_CMD, 8'h00); // opens a fresh address phase
      go(`OP_ADDR, 8'h00);
      `CHK(dev_u.acnt, t ? `ADDR_BYTES_LARGE : `ADDR_BYTES_SMALL)
      `CHK(dev_u.ab[0], ce[7:0])
      `CHK(dev_u.ab[1], {4'h0, ce[11:8]})
      `CHK(dev_u.ab[2], {b[1:0], p})
      `CHK(dev_u.ab[3], b[9:2])
      if (t)
        `CHK(dev_u.ab[4], {7'h0, b[10]})
    end
  endtask
  // program four bytes, then try again with protection on
  task t_write;
    integer k;
    begin
      t_addr(1'b0, 12'h000, 6'h3f, 11'h3ff);
      go(`OP_CMD, 8'h80);
      for (k = 0; k < 4; k = k + 1)
        go(`OP_WRITE, 8'h11 * (k + 1));
      go(`OP_CMD, 8'h10);
      `CHK(dev_u.buf_m[3], 8'h44)
      `CHK(dev_u.pcnt, 4'h1)
      @(posedge clock_in);
      wp <= 1'b0;
      t_addr(1'b0, 12'h000, 6'h00, 11'h000);
      go(`OP_WRITE, 8'hee);
      go(`OP_CMD, 8'h10);
      `CHK(dev_u.buf_m[0], 8'h11)
      `CHK(dev_u.pcnt, 4'h1)
      @(posedge clock_in);
      wp <= 1'b1;
    end
  endtask
  // queue n reads with rd stalled (n of 4 fills the fifo), then drain in order
  task t_read(input [3:0] n, input [7:0] e0, input [7:0] st);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1)
        go(`OP_READ, 8'h00);
      // ready is registered and trails the last push by one cycle
      @(negedge clock_in);
      `CHK(op_ready_out, n[2]  ? 1'b0 : 1'b1)
      for (k = 0; k < n; k = k + 1)
      begin
        @(negedge clock_in);
        `CHK(rd_data_out, e0 + st * k)
        @(posedge clock_in);
        rd_ready_in <= 1'b1;
        @(posedge clock_in);
        rd_ready_in <= 1'b0;
      end
      @(negedge clock_in);
      `CHK(rd_valid_out, 1'b0)
    end
  endtask
  initial
  begin
    repeat (5) @(posedge clock_in);
    nrst_in <= 1'b1;
    t_addr(1'b1, 12'habc, 6'h2a, 11'h5a5);
    t_addr(1'b0, 12'h8c3, 6'h15, 11'h7ff);
    t_write;
    t_addr(1'b1, 12'h000, 6'h01, 11'h400);
    t_read(4'h4, 8'h11, 8'h11);
    go(`OP_CMD, 8'h30);
    @(negedge clock_in);
    `CHK(op_ready_out, 1'b0)
    go(`OP_CMD, 8'h90);
    t_read(4'h1, 8'h5c, 8'h00);
    summarize;
  end
endmodule // tb_top
bind nand_host nand_host_chk chk_u (.*);
